//--- design/dsw_watchdog.sv
/*
  Deep sleep watchdog: counts a selected low-speed oscillator through a
  fixed prescaler and a fuse-selected postscaler and raises a wake pulse.
  Assumes the configuration byte is stable fuse data on i_mclk, that
  i_deep_sleep comes from power control logic on i_mclk, and that the two
  oscillator inputs are free-running pins of unrelated phase, much slower
  than i_mclk.
*/
`timescale 1ns/1ps
module dsw_watchdog
  import dsw_pkg::*;
(
  input  wire logic             i_mclk,
  input  wire logic             i_rst_b,
  input  wire logic [CFG_W-1:0] i_config_byte,
  input  wire logic             i_deep_sleep,
  input  wire logic             i_sec_osc_clk,
  input  wire logic             i_rc_osc_clk,
  output logic                  o_sec_osc_en,
  output logic                  o_rc_osc_en,
  output logic                  o_timeout,
  output logic                  o_wake
);

  typedef struct packed {
    dsw_state_t        state;
    logic              cfg_en;
    logic              cfg_sel;
    logic [PS_W-1:0]   cfg_ps;
    logic [SYNC_N-1:0] sec_sync;
    logic [SYNC_N-1:0] rc_sync;
    logic              sec_lvl;
    logic              rc_lvl;
    logic              ds_prev;
    logic [POST_W-1:0] post_cnt;
    logic              sec_en;
    logic              rc_en;
    logic              timeout;
    logic              wake;
  } dsw_state_vec_t;

  dsw_state_vec_t s;
  dsw_state_vec_t next_s;

  logic              base_tick;
  logic              osc_tick;
  logic              sec_rise;
  logic              rc_rise;
  logic              sleep_entry;
  logic              pre_clear;
  logic [POST_W-1:0] post_limit;

  // Terminal count is ratio minus one; ratio is 2^(2*code+1)
  function automatic logic [POST_W-1:0] ratio_last(
    input logic [PS_W-1:0] code
  );
    logic [PS_W:0] shift;
    shift = {code, 1'b1};
    return (POST_ONE << shift) - POST_ONE;
  endfunction

  // A rise counts only once the second and third stages agree on it;
  // the unselected pin is ignored even while its oscillator runs
  assign sec_rise    = s.sec_sync[SYNC_N-1] && s.sec_sync[SYNC_N-2]
                       && !s.sec_lvl;
  assign rc_rise     = s.rc_sync[SYNC_N-1] && s.rc_sync[SYNC_N-2]
                       && !s.rc_lvl;
  assign osc_tick    = (s.cfg_sel == SEL_RC_OSC) ? rc_rise : sec_rise;
  assign sleep_entry = i_deep_sleep && !s.ds_prev;
  assign pre_clear   = sleep_entry || (s.state != DSW_RUN);
  assign post_limit  = ratio_last(s.cfg_ps);

  dsw_prescaler dsw_prescaler_i (
    .i_mclk      (i_mclk),
    .i_rst_b     (i_rst_b),
    .i_clear     (pre_clear),
    .i_tick      (osc_tick),
    .o_base_tick (base_tick)
  );

  // Next-state logic for the watchdog apart from the prescaler
  always_comb begin
    next_s         = s;
    next_s.timeout = 1'b0;
    next_s.wake    = 1'b0;
    next_s.ds_prev = i_deep_sleep;

    // Oscillator pins pass three flops; first stage feeds only the second
    next_s.sec_sync = {s.sec_sync[SYNC_N-2:0], i_sec_osc_clk};
    next_s.rc_sync  = {s.rc_sync[SYNC_N-2:0], i_rc_osc_clk};
    // Level follows only agreeing stages, so a glitch is never counted
    if (s.sec_sync[SYNC_N-1] == s.sec_sync[SYNC_N-2]) begin
      next_s.sec_lvl = s.sec_sync[SYNC_N-1];
    end
    if (s.rc_sync[SYNC_N-1] == s.rc_sync[SYNC_N-2]) begin
      next_s.rc_lvl = s.rc_sync[SYNC_N-1];
    end

    unique case (s.state)
      // Fuses are caught once after reset; they cannot change at run time
      DSW_LOAD: begin
        next_s.cfg_en   = i_config_byte[CFG_EN_BIT];
        next_s.cfg_sel  = i_config_byte[CFG_SEL_BIT];
        next_s.cfg_ps   = i_config_byte[CFG_PS_MSB:CFG_PS_LSB];
        next_s.post_cnt = POST_ZERO;
        if (i_config_byte[CFG_EN_BIT]) begin
          next_s.state   = DSW_RUN;
          next_s.rc_en  = (i_config_byte[CFG_SEL_BIT] == SEL_RC_OSC);
          next_s.sec_en = (i_config_byte[CFG_SEL_BIT] != SEL_RC_OSC);
        end else begin
          next_s.state = DSW_OFF;
        end
      end
      DSW_OFF: begin
        next_s.post_cnt = POST_ZERO;
      end
      DSW_RUN: begin
        // Keeps counting in every power mode, deep sleep included
        if (sleep_entry) begin
          next_s.post_cnt = POST_ZERO;
        end else if (base_tick) begin
          if (s.post_cnt == post_limit) begin
            next_s.post_cnt = POST_ZERO;
            next_s.timeout  = 1'b1;
            next_s.wake     = i_deep_sleep;
          end else begin
            next_s.post_cnt = s.post_cnt + POST_ONE;
          end
        end
      end
      // Two state bits leave one code unused; recover through a new load
      default: begin
        next_s.state = DSW_LOAD;
      end
    endcase
  end

  // All state sits in one register; reset loads constants only
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_sec_osc_en = s.sec_en;
  assign o_rc_osc_en  = s.rc_en;
  assign o_timeout    = s.timeout;
  assign o_wake       = s.wake;

  // Enabled watchdog counts in deep sleep
  ds_running_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    s.cfg_en && s.state != DSW_LOAD |-> s.state == DSW_RUN)
    else $error("enabled watchdog not running");

  clk_select_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    s.state == DSW_RUN |-> (o_rc_osc_en == (s.cfg_sel == SEL_RC_OSC))
      && (o_sec_osc_en != o_rc_osc_en))
    else $error("wrong oscillator enabled");

  ps_capture_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    s.state == DSW_LOAD |=> s.cfg_ps ==
      $past(i_config_byte[CFG_PS_MSB:CFG_PS_LSB]))
    else $error("postscale code not captured");

  osc_auto_en_a: assert property (@(posedge i_mclk)
    disable iff (!i_rst_b)
    s.state == DSW_LOAD && i_config_byte[CFG_EN_BIT]
      |=> o_sec_osc_en || o_rc_osc_en)
    else $error("clock source not enabled with watchdog");

  wake_cause_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_wake |-> o_timeout && $past(i_deep_sleep))
    else $error("wake without expiry in deep sleep");

  expiry_point_a: assert property (@(posedge i_mclk)
    disable iff (!i_rst_b)
    s.state == DSW_RUN && base_tick && !sleep_entry
      && s.post_cnt == post_limit
      |=> o_timeout ##1 !o_timeout)
    else $error("expiry not at terminal count");

  disabled_quiet_a: assert property (@(posedge i_mclk)
    disable iff (!i_rst_b)
    s.state == DSW_OFF |-> !o_timeout && !o_sec_osc_en && !o_rc_osc_en)
    else $error("disabled watchdog active");

  sleep_restart_a: assert property (@(posedge i_mclk)
    disable iff (!i_rst_b)
    s.state == DSW_RUN && sleep_entry |=> s.post_cnt == POST_ZERO)
    else $error("postscaler not restarted on sleep entry");

  // Postscale count never passes the terminal count of its code
  post_bound_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    s.state == DSW_RUN |-> s.post_cnt <= post_limit)
    else $error("postscale count beyond terminal count");

  // Each pin rise is counted once, however long the pin stays high
  tick_once_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    s.state == DSW_RUN && osc_tick |=> !osc_tick)
    else $error("oscillator rise counted twice");

  // Prescaler gives no tick right after a restart or while idle
  pre_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    pre_clear |=> !base_tick)
    else $error("base tick after prescaler restart");

  // An expiry seen in deep sleep always carries a wake
  exp_wake_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_timeout && $past(i_deep_sleep) |-> o_wake)
    else $error("expiry in deep sleep without wake");

  wake_c: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_wake);
  awake_expiry_c: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_timeout && !o_wake);
  sleep_entry_c: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
    s.state == DSW_RUN && sleep_entry && s.post_cnt != POST_ZERO);
  rc_run_c: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_rc_osc_en ##1 o_timeout);
  disabled_c: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
    s.state == DSW_OFF);

endmodule // dsw_watchdog

//--- include/dsw_pkg.sv
/*
  Constants and types shared by the deep sleep watchdog and its prescaler.
  Assumes the configuration byte is presented by fuse logic on i_mclk.
*/
package dsw_pkg;

  // Deep sleep configuration byte layout
  localparam int unsigned CFG_W        = 8;
  localparam int unsigned CFG_EN_BIT   = 7;
  localparam int unsigned CFG_SEL_BIT  = 4;
  localparam int unsigned CFG_PS_MSB   = 3;
  localparam int unsigned CFG_PS_LSB   = 0;
  localparam int unsigned PS_W         = 4;

  // Value of the clock select bit that picks the low power RC oscillator
  localparam logic        SEL_RC_OSC   = 1'h1;

  // Fixed prescaler: divide by 32 for a base tick near 1 ms
  localparam int unsigned PRE_DIV      = 32;
  localparam int unsigned PRE_W        = 5;
  localparam logic [PRE_W-1:0] PRE_LAST = 5'h1f;
  localparam logic [PRE_W-1:0] PRE_ZERO = 5'h00;

  // Postscaler counter holds up to a 1:2^31 ratio
  localparam int unsigned POST_W       = 32;
  localparam logic [POST_W-1:0] POST_ONE  = 32'h1;
  localparam logic [POST_W-1:0] POST_ZERO = 32'h0;

  // Synchroniser depth for the oscillator inputs
  localparam int unsigned SYNC_N       = 3;

  typedef enum logic [1:0] {
    DSW_LOAD,
    DSW_OFF,
    DSW_RUN
  } dsw_state_t;

endpackage

//--- design/dsw_prescaler.sv
/*
  Fixed divide-by-32 prescaler of the deep sleep watchdog.
  Assumes i_tick is a one-cycle pulse per rising edge of the selected low-speed
  oscillator, already synchronised to i_mclk.
*/
`timescale 1ns/1ps
module dsw_prescaler
  import dsw_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_rst_b,
  input  wire logic i_clear,
  input  wire logic i_tick,
  output logic      o_base_tick
);

  typedef struct packed {
    logic [PRE_W-1:0] cnt;
    logic             base;
  } dsw_pre_t;

  dsw_pre_t s;
  dsw_pre_t next_s;

  // Count oscillator ticks; a clear always restarts a full base period
  always_comb begin
    next_s      = s;
    next_s.base = 1'b0;
    if (i_clear) begin
      next_s.cnt = PRE_ZERO;
    end else if (i_tick) begin
      next_s.cnt  = s.cnt + PRE_W'(1);
      next_s.base = (s.cnt == PRE_LAST);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_base_tick = s.base;

  // One base tick per 32 ticks, never after a clear
  pre_div_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_base_tick |-> $past(s.cnt) == PRE_LAST && $past(i_tick)
      && !$past(i_clear))
    else $error("base tick without a full prescaler count");

  pre_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_clear |=> s.cnt == PRE_ZERO && !o_base_tick)
    else $error("prescaler not restarted by clear");

endmodule // dsw_prescaler

//--- testbench/dsw_watchdog_bench.sv
/*
  Self-checking bench for the deep sleep watchdog top module.
  Assumes the design's own assertions sit in its files; the bench only
  drives the ports, checks the oscillator enables and counts timeout and wake pulses.
*/
`timescale 1ns/1ps
module dsw_watchdog_bench;
  import dsw_pkg::*;

  logic             i_mclk;
  logic             i_rst_b;
  logic [CFG_W-1:0] i_config_byte;
  logic             i_deep_sleep;
  logic             i_sec_osc_clk;
  logic             i_rc_osc_clk;
  logic             o_sec_osc_en;
  logic             o_rc_osc_en;
  logic             o_timeout;
  logic             o_wake;
  int               n_fail;
  int               cmp_count;
  int               n_tout;
  int               n_wake;

  dsw_watchdog dsw_watchdog_i (
    .i_mclk        (i_mclk),
    .i_rst_b       (i_rst_b),
    .i_config_byte (i_config_byte),
    .i_deep_sleep  (i_deep_sleep),
    .i_sec_osc_clk (i_sec_osc_clk),
    .i_rc_osc_clk  (i_rc_osc_clk),
    .o_sec_osc_en  (o_sec_osc_en),
    .o_rc_osc_en   (o_rc_osc_en),
    .o_timeout     (o_timeout),
    .o_wake        (o_wake)
  );

  // 200 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  // Pulses are one cycle wide; count them mid-cycle, where they are settled
  always @(negedge i_mclk) begin
    if (o_timeout === 1'b1) n_tout++;
    if (o_wake === 1'b1) n_wake++;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Fuses are latched once after release, so each setup needs a reset
  task automatic do_reset(input logic [CFG_W-1:0] cfg);
    @(posedge i_mclk);
    i_rst_b       <= 1'b0;
    i_config_byte <= cfg;
    i_deep_sleep  <= 1'b0;
    i_sec_osc_clk <= 1'b0;
    i_rc_osc_clk  <= 1'b0;
    repeat (5) @(posedge i_mclk);
    check({o_timeout, o_wake, o_sec_osc_en, o_rc_osc_en}, 32'h0);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_mclk);
    n_tout = 0;
    n_wake = 0;
    if (cfg[CFG_EN_BIT]) begin
      check(o_rc_osc_en, cfg[CFG_SEL_BIT] == SEL_RC_OSC);
      check(o_sec_osc_en, cfg[CFG_SEL_BIT] != SEL_RC_OSC);
    end else begin
      check({o_sec_osc_en, o_rc_osc_en}, 32'h0);
    end
  endtask

  // Each level is held 3 cycles, one more than the 2 the synchroniser needs
  task automatic drive(input logic sel, input logic a, input logic b);
    @(posedge i_mclk);
    i_rc_osc_clk  <= sel ? a : b;
    i_sec_osc_clk <= sel ? b : a;
    repeat (2) @(posedge i_mclk);
  endtask

  // The unselected pin toggles twice as fast to expose any leakage
  task automatic rises(input logic sel, input int n);
    for (int i = 0; i < n; i++) begin
      drive(sel, 1'b1, 1'b1);
      drive(sel, 1'b1, 1'b0);
      drive(sel, 1'b0, 1'b1);
      drive(sel, 1'b0, 1'b0);
    end
    repeat (8) @(posedge i_mclk);
  endtask

  // Exact expiry count for a postscale code, on the oscillator its low bit selects
  task automatic scen_ratio(input logic [PS_W-1:0] c);
    int n;
    n = 32 << (2 * c + 1);
    do_reset({1'b1, 2'b00, c[0], c});
    rises(c[0], n - 1);
    check(n_tout, 0);
    rises(c[0], 1);
    check(n_tout, 1);
    check(n_wake, 0);
    if (c == 0) begin
      rises(c[0], n);
      check(n_tout, 2);
    end
  endtask

  // Enable fuse cleared: no expiry however long it runs
  task automatic scen_disabled;
    do_reset(8'h01);
    rises(1'b0, 300);
    rises(1'b1, 300);
    check(n_tout, 0);
  endtask

  // Entry to deep sleep restarts the count; expiry then wakes
  task automatic scen_sleep;
    do_reset(8'h90);
    rises(1'b1, 40);
    @(posedge i_mclk);
    i_deep_sleep <= 1'b1;
    rises(1'b1, 63);
    check(n_tout, 0);
    rises(1'b1, 1);
    check(n_tout, 1);
    check(n_wake, 1);
  endtask

  // Bound on the whole run
  initial begin
    repeat (90000) @(posedge i_mclk);
    n_fail++;
    conclude();
  end

  initial begin
    n_fail        = 0;
    cmp_count     = 0;
    i_rst_b       = 1'b0;
    i_config_byte = 8'h00;
    i_deep_sleep  = 1'b0;
    i_sec_osc_clk = 1'b0;
    i_rc_osc_clk  = 1'b0;
    for (int c = 0; c < 3; c++) scen_ratio(c[PS_W-1:0]);
    scen_disabled();
    scen_sleep();
    conclude();
  end
endmodule // dsw_watchdog_bench
